// ---- verilog/dcs_pkg.sv ----
// Purpose: constants and types for the down-counter start control block
// Assumes: APB slave with 32-bit data, one word per register
// Notes: register offsets are byte addresses
package dcs_pkg;
  localparam int unsigned NUM_CTR = 16;
  localparam int unsigned CW = 16;
  localparam int unsigned NUM_RLD = 8;
  localparam int unsigned FIRST_RLD_CTR = 8;
  localparam logic [7:0] OFS_START = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_LINK = 8'h08;
  localparam logic [7:0] OFS_STOP = 8'h0C;
  localparam logic [7:0] OFS_RLD_ON = 8'h10;
  localparam logic [7:0] OFS_RLD_VAL = 8'h14;
  localparam logic [7:0] OFS_PRESC = 8'h18;
  localparam logic [7:0] OFS_CTR_BASE = 8'h40;
  localparam logic [7:0] OFS_CTR_LAST = 8'h7C;
  localparam int unsigned MODE_OFFSET_BIT = 0;
  localparam int unsigned MODE_TRIG_BIT = 7;
  localparam logic [15:0] START_RST = 16'h0000;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] LINK_RST = 16'h0000;
  localparam logic [15:0] STOP_RST = 16'h0000;
  localparam logic [7:0] RLD_ON_RST = 8'h00;
  localparam logic [15:0] RLD_VAL_RST = 16'h0000;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [15:0] CTR_ZERO = 16'h0000;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_START, SEL_MODE, SEL_LINK, SEL_STOP,
    SEL_RLD_ON, SEL_RLD_VAL, SEL_PRESC, SEL_CTR
  } dcs_sel_type;

  // compare-match events from channels 1 and 2, one-cycle pulses
  typedef struct packed {
    logic ch1_ocr;
    logic [7:0] ch1_gr;
    logic [7:0] ch2_ocr;
    logic [7:0] ch2_gr;
  } dcs_evt_type;
endpackage

// ---- verilog/dcs_sync.sv ----
// Purpose: two-flop synchroniser for pin-level inputs
// Assumes: inputs are slow levels
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module dcs_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,        // block clock
  input wire logic rst_n,      // async reset, active low
  input wire logic [W-1:0] d,  // asynchronous level
  output logic [W-1:0] q       // synchronised level
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/dcs_down_ctr.sv ----
// Purpose: one 16-bit down-counter with reload and underflow pulse
// Assumes: tick is a one-cycle enable from the prescaler
// Notes: reload beats a software load
`timescale 1ns/10ps
`default_nettype none
module dcs_down_ctr
  import dcs_pkg::*;
(
  input wire logic clk,             // block clock
  input wire logic rst_n,           // async reset, active low
  input wire logic clr,             // standby: force to zero
  input wire logic tick,            // count enable pulse
  input wire logic run,             // start flag
  input wire logic load,            // software write
  input wire logic [CW-1:0] load_val, // software value
  input wire logic rld,             // reload request
  input wire logic [CW-1:0] rld_val,  // reload value
  output logic [CW-1:0] count_q,    // counter value
  output logic uf_q                 // underflow pulse
);
  logic [CW-1:0] count_d;
  logic uf_d;

  always_comb begin
    count_d = count_q;
    uf_d = 1'b0;
    if (clr) begin
      count_d = CTR_ZERO;
    end else if (rld) begin
      count_d = rld_val;
    end else if (load) begin
      count_d = load_val;
    end else if (run && tick) begin
      if (count_q == CTR_ZERO) begin
        uf_d = 1'b1;
        count_d = CTR_ZERO;
      end else begin
        count_d = count_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= CTR_ZERO;
      uf_q <= 1'b0;
    end else begin
      count_q <= count_d;
      uf_q <= uf_d;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/dcs_start_ctrl.sv ----
// Purpose: start control for sixteen down-counters, APB register slave
// Assumes: compare events come from logic on REF_CLK; standby pins are asynchronous
// Notes: zero-wait APB, read data registered in the setup cycle
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module dcs_start_ctrl
  import dcs_pkg::*;
(
  input wire logic REF_CLK,           // 10 MHz timer clock
  input wire logic RST_N,             // power-on reset, async, active low
  input wire logic HW_STANDBY_N,      // hardware standby pin, active low
  input wire logic SW_STANDBY,        // software standby request
  input wire logic PSEL,              // apb select
  input wire logic PENABLE,           // apb access phase
  input wire logic PWRITE,            // apb direction
  input wire logic [7:0] PADDR,       // apb byte address
  input wire logic [31:0] PWDATA,     // apb write data
  output logic [31:0] PRDATA,         // apb read data
  output logic PREADY,                // apb ready
  output logic PSLVERR,               // apb error on unmapped address
  input wire dcs_evt_type EVT,        // compare-match pulses
  output logic [NUM_CTR-1:0] COUNTER_RUN, // start flags
  output logic [NUM_CTR-1:0] UNDERFLOW    // underflow pulses
);
  logic hstby_n_s;
  logic sstby_s;
  logic stby;

  dcs_sync #(.W(1), .RST_VAL(1'b1)) u_sync_h (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d(HW_STANDBY_N),
    .q(hstby_n_s)
  );
  dcs_sync #(.W(1), .RST_VAL(1'b0)) u_sync_s (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d(SW_STANDBY),
    .q(sstby_s)
  );
  assign stby = !hstby_n_s || sstby_s;

  // address decode, shared by the write and the read path
  function automatic dcs_sel_type decode(input logic [7:0] a);
    dcs_sel_type s;
    s = SEL_NONE;
    unique case (a)
      OFS_START: s = SEL_START;
      OFS_MODE: s = SEL_MODE;
      OFS_LINK: s = SEL_LINK;
      OFS_STOP: s = SEL_STOP;
      OFS_RLD_ON: s = SEL_RLD_ON;
      OFS_RLD_VAL: s = SEL_RLD_VAL;
      OFS_PRESC: s = SEL_PRESC;
      default: begin
        if (a >= OFS_CTR_BASE && a <= OFS_CTR_LAST && a[1:0] == 2'b00) begin
          s = SEL_CTR;
        end
      end
    endcase
    return s;
  endfunction

  // channel-1 routing: trigger select swaps the start and terminate roles
  function automatic logic ch1_pick(input logic trig, input logic on_one, input logic on_zero);
    return trig ? on_one : on_zero;
  endfunction

  dcs_sel_type sel;
  logic wr_acc;
  logic [3:0] ctr_idx;
  assign sel = decode(PADDR);
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign ctr_idx = PADDR[5:2];
  assign PREADY = 1'b1;

  // configuration registers
  logic [15:0] start_q, start_d;
  logic [7:0] mode_q, mode_d;
  logic [15:0] link_q, link_d;
  logic [15:0] stop_q, stop_d;
  logic [7:0] rld_on_q, rld_on_d;
  logic [15:0] rld_val_q, rld_val_d;
  logic [7:0] presc_q, presc_d;
  logic offset_mode;
  logic trig_sel;
  assign offset_mode = mode_q[MODE_OFFSET_BIT];
  assign trig_sel = mode_q[MODE_TRIG_BIT];

  always_comb begin
    mode_d = mode_q;
    link_d = link_q;
    stop_d = stop_q;
    rld_on_d = rld_on_q;
    rld_val_d = rld_val_q;
    presc_d = presc_q;
    if (stby) begin
      mode_d = MODE_RST;
      link_d = LINK_RST;
      stop_d = STOP_RST;
      rld_on_d = RLD_ON_RST;
      rld_val_d = RLD_VAL_RST;
      presc_d = PRESC_RST;
    end else if (wr_acc) begin
      if (sel == SEL_MODE) begin
        mode_d[MODE_OFFSET_BIT] = PWDATA[MODE_OFFSET_BIT];
        mode_d[MODE_TRIG_BIT] = PWDATA[MODE_TRIG_BIT];
      end
      if (sel == SEL_LINK) begin
        link_d = PWDATA[15:0];
      end
      if (sel == SEL_STOP) begin
        stop_d = PWDATA[15:0];
      end
      if (sel == SEL_RLD_ON) begin
        rld_on_d = PWDATA[7:0];
      end
      if (sel == SEL_RLD_VAL) begin
        rld_val_d = PWDATA[15:0];
      end
      if (sel == SEL_PRESC) begin
        presc_d = PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q <= MODE_RST;
      link_q <= LINK_RST;
      stop_q <= STOP_RST;
      rld_on_q <= RLD_ON_RST;
      rld_val_q <= RLD_VAL_RST;
      presc_q <= PRESC_RST;
    end else begin
      mode_q <= mode_d;
      link_q <= link_d;
      stop_q <= stop_d;
      rld_on_q <= rld_on_d;
      rld_val_q <= rld_val_d;
      presc_q <= presc_d;
    end
  end

  // count clock prescaler: one tick every presc_q+1 cycles
  logic [7:0] pre_q, pre_d;
  logic tick_q, tick_d;
  always_comb begin
    pre_d = pre_q + 8'h01;
    tick_d = 1'b0;
    if (pre_q >= presc_q) begin
      pre_d = 8'h00;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end

  // per-counter start, terminate, reload and flag logic
  logic [CW-1:0] cnt [NUM_CTR];
  logic [NUM_CTR-1:0] uf;
  logic [NUM_CTR-1:0] sw_set;
  logic [NUM_CTR-1:0] hw_set;
  logic [NUM_CTR-1:0] term;
  logic [NUM_CTR-1:0] rld;
  logic [NUM_CTR-1:0] ld;
  logic [NUM_CTR-1:0] start_evt;
  logic [NUM_CTR-1:0] term_evt;

  for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
    if (i < FIRST_RLD_CTR) begin : g_ch1
      assign start_evt[i] = ch1_pick(trig_sel, EVT.ch1_gr[i], EVT.ch1_ocr);
      assign term_evt[i] = ch1_pick(trig_sel, EVT.ch1_ocr, EVT.ch1_gr[i]);
      assign rld[i] = 1'b0;
    end else begin : g_ch2
      // counter P pairs with ch2 H, counter O with ch2 G
      assign start_evt[i] = EVT.ch2_ocr[i-FIRST_RLD_CTR];
      assign term_evt[i] = EVT.ch2_gr[i-FIRST_RLD_CTR];
      assign rld[i] = offset_mode && link_q[i] && start_evt[i] && !stby
        && rld_on_q[i-FIRST_RLD_CTR] && (rld_val_q != CTR_ZERO);
    end
    // a reload also counts as a nonzero start
    assign sw_set[i] = wr_acc && sel == SEL_START && PWDATA[i] && cnt[i] != CTR_ZERO;
    assign hw_set[i] = offset_mode && link_q[i] && start_evt[i]
      && (cnt[i] != CTR_ZERO || rld[i]);
    assign term[i] = uf[i] || (stop_q[i] && term_evt[i]);
    assign ld[i] = wr_acc && sel == SEL_CTR && ctr_idx == 4'(i);

    dcs_down_ctr u_ctr (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .clr(stby),
      .tick(tick_q),
      .run(start_q[i]),
      .load(ld[i]),
      .load_val(PWDATA[15:0]),
      .rld(rld[i]),
      .rld_val(rld_val_q),
      .count_q(cnt[i]),
      .uf_q(uf[i])
    );
  end

  // set wins over a same-cycle terminate so no start is lost
  always_comb begin
    start_d = (start_q & ~term) | sw_set | hw_set;
    if (stby) begin
      start_d = START_RST;
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      start_q <= START_RST;
    end else begin
      start_q <= start_d;
    end
  end

  assign COUNTER_RUN = start_q;
  assign UNDERFLOW = uf;

  // read data and error captured in the setup cycle
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  always_comb begin
    rdata_d = rdata_q;
    err_d = err_q;
    if (PSEL && !PENABLE) begin
      rdata_d = 32'h0000_0000;
      err_d = (sel == SEL_NONE);
      unique case (sel)
        SEL_START: rdata_d[15:0] = start_q;
        SEL_MODE: rdata_d[7:0] = mode_q;
        SEL_LINK: rdata_d[15:0] = link_q;
        SEL_STOP: rdata_d[15:0] = stop_q;
        SEL_RLD_ON: rdata_d[7:0] = rld_on_q;
        SEL_RLD_VAL: rdata_d[15:0] = rld_val_q;
        SEL_PRESC: rdata_d[7:0] = presc_q;
        SEL_CTR: rdata_d[15:0] = cnt[ctr_idx];
        SEL_NONE: rdata_d = 32'h0000_0000;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end
  assign PRDATA = rdata_q;
  assign PSLVERR = err_q && PSEL && PENABLE;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  property p_flag_falls_on_cause;
    $fell(start_q[0]) |-> $past(term[0]) || $past(stby);
  endproperty
  a_flag_falls_on_cause: assert property (p_flag_falls_on_cause) else $error("flag fell without cause");

  property p_sw_set;
    wr_acc && sel == SEL_START && PWDATA[0] && cnt[0] != CTR_ZERO && !stby |=> start_q[0];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set lost");

  property p_zero_refused;
    !start_q[1] && cnt[1] == CTR_ZERO && !hw_set[1] |=> !start_q[1];
  endproperty
  a_zero_refused: assert property (p_zero_refused) else $error("set accepted at zero");

  // counter P sits loaded while halted, so a stray step would show here
  property p_halted;
    !start_q[15] && !ld[15] && !rld[15] && !stby |=> $stable(cnt[15]);
  endproperty
  a_halted: assert property (p_halted) else $error("halted counter moved");

  property p_decrement;
    start_q[0] && tick_q && cnt[0] > 16'h0001 && !ld[0] && !stby |=> cnt[0] == $past(cnt[0]) - 16'h0001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("counter did not step down");

  property p_uf_zero;
    uf[0] |-> cnt[0] == CTR_ZERO ##1 !start_q[0] || $past(sw_set[0] || hw_set[0]);
  endproperty
  a_uf_zero: assert property (p_uf_zero) else $error("underflow handling wrong");

  property p_standby;
    stby |=> start_q == START_RST;
  endproperty
  a_standby: assert property (p_standby) else $error("standby left a flag set");

  property p_ch1_start;
    offset_mode && !trig_sel && link_q[0] && EVT.ch1_ocr && cnt[0] != CTR_ZERO && !stby |=> start_q[0];
  endproperty
  a_ch1_start: assert property (p_ch1_start) else $error("channel-1 start missed");

  property p_swap;
    trig_sel && stop_q[0] && EVT.ch1_ocr && !sw_set[0] && !hw_set[0] |=> !start_q[0];
  endproperty
  a_swap: assert property (p_swap) else $error("swapped terminate missed");

  property p_p_stop;
    stop_q[15] && EVT.ch2_gr[7] && !sw_set[15] && !hw_set[15] |=> !start_q[15];
  endproperty
  a_p_stop: assert property (p_p_stop) else $error("counter P not stopped");

  property p_reload;
    rld[14] |=> start_q[14] && cnt[14] == $past(rld_val_q);
  endproperty
  a_reload: assert property (p_reload) else $error("reload not taken");

  // covers mark the paths that the bench is meant to reach
  c_reload: cover property (rld[14]);
  c_swap_stop: cover property (trig_sel && stop_q[0] && EVT.ch1_ocr);
  c_underflow: cover property (start_q[0] ##1 uf[0]);
  c_set_clear: cover property (sw_set[1] && term[1]);
endmodule
`default_nettype wire

// ---- verification/dcs_start_ctrl_test.sv ----
// Purpose: self-checking bench for the down-counter start control block
// Assumes: zero-wait APB slave; bench drives every input on the rising edge
// Notes: the reload read tolerates one prescaler tick landing on the edge after the reload edge
`timescale 1ns/10ps
`default_nettype none
module dcs_start_ctrl_test
  import dcs_pkg::*;
;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } dcs_row_type;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hw_sb_n = 1'b1;
  logic sw_sb = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dcs_evt_type evt = '0;
  logic [15:0] run;
  logic [15:0] uf;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  logic [31:0] r;
  logic e;
  dcs_row_type rows [9];

  dcs_start_ctrl dcs_start_ctrl_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .HW_STANDBY_N(hw_sb_n),
    .SW_STANDBY(sw_sb), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EVT(evt),
    .COUNTER_RUN(run), .UNDERFLOW(uf));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // whole run is well under this; a hang ends here
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches = mismatches + 1;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // this wait ends once pready reads 1; the bench timeout ends it on a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  function automatic dcs_evt_type mk(input logic o1, input logic [7:0] g1, input logic [7:0] o2,
    input logic [7:0] g2);
    mk = {o1, g1, o2, g2};
  endfunction

  // one-cycle event pulse, then look after the sampling edge has settled
  task automatic ev(input dcs_evt_type v);
    @(posedge ref_clk);
    evt <= v;
    @(posedge ref_clk);
    evt <= '0;
  endtask

  task automatic see_run(input logic [15:0] x);
    @(negedge ref_clk);
    chk({16'h0, run}, {16'h0, x});
  endtask

  initial begin
    rows = '{'{OFS_MODE, 32'h0000_00FF, 32'h0000_0081, 1'b0},
             '{OFS_LINK, 32'hFFFF_0003, 32'h0000_0003, 1'b0},
             '{OFS_STOP, 32'hFFFF_8001, 32'h0000_8001, 1'b0},
             '{OFS_RLD_ON, 32'hFFFF_FF40, 32'h0000_0040, 1'b0},
             '{OFS_RLD_VAL, 32'h0001_2345, 32'h0000_2345, 1'b0},
             '{OFS_PRESC, 32'h0000_01FF, 32'h0000_00FF, 1'b0},
             '{OFS_CTR_BASE, 32'h0000_0005, 32'h0000_0005, 1'b0},
             '{OFS_CTR_LAST, 32'h0000_0003, 32'h0000_0003, 1'b0},
             '{8'h20, 32'h0000_0055, 32'h0000_0000, 1'b1}};
    repeat (6) @(posedge ref_clk);
    chk({16'h0, run}, 32'h0);
    rst_n <= 1'b1;
    rd(OFS_START, 32'h0);
    foreach (rows[i]) begin
      rd(rows[i].a, 32'h0);
      wr(rows[i].a, rows[i].d);
      chk({31'h0, e}, {31'h0, rows[i].e});
      rd(rows[i].a, rows[i].x);
    end
    // counter B holds zero, so its bit must be refused
    wr(OFS_START, 32'h3);
    see_run(16'h0001);
    wr(OFS_START, 32'h0);
    rd(OFS_START, 32'h1);
    wr(OFS_START, 32'h8000);
    see_run(16'h8001);
    ev(mk(1'b0, 8'h00, 8'h00, 8'h80));
    see_run(16'h0001);
    ev(mk(1'b1, 8'h00, 8'h00, 8'h00));
    see_run(16'h0000);
    ev(mk(1'b0, 8'h03, 8'h00, 8'h00));
    see_run(16'h0001);
    wr(OFS_MODE, 32'h1);
    ev(mk(1'b0, 8'h01, 8'h00, 8'h00));
    see_run(16'h0000);
    ev(mk(1'b1, 8'h00, 8'h00, 8'h00));
    see_run(16'h0001);
    wr(OFS_LINK, 32'h4003);
    ev(mk(1'b0, 8'h00, 8'h40, 8'h00));
    see_run(16'h4001);
    apb(1'b0, 8'h78, 32'h0);
    chk(r, (r === 32'h2344) ? 32'h2344 : 32'h2345);
    // terminate disabled for counter O: flag must survive the match
    ev(mk(1'b0, 8'h00, 8'h00, 8'h40));
    see_run(16'h4001);
    wr(OFS_STOP, 32'hC001);
    ev(mk(1'b0, 8'h00, 8'h00, 8'h40));
    see_run(16'h0001);
    ev(mk(1'b0, 8'h01, 8'h00, 8'h00));
    see_run(16'h0000);
    wr(OFS_PRESC, 32'h0);
    wr(OFS_CTR_BASE, 32'h4);
    wr(OFS_START, 32'h1);
    n = 0;
    while (uf[0] !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    // start edge, four steps down, then the underflow tick
    chk(32'(n), 32'h6);
    see_run(16'h0000);
    rd(OFS_CTR_BASE, 32'h0);
    apb(1'b0, OFS_CTR_LAST, 32'h0);
    n = r;
    repeat (20) @(posedge ref_clk);
    rd(OFS_CTR_LAST, n);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTR_BASE, 32'h100);
      wr(OFS_START, 32'h1);
      see_run(16'h0001);
      @(posedge ref_clk);
      if (k == 0) begin
        hw_sb_n <= 1'b0;
      end else begin
        sw_sb <= 1'b1;
      end
      repeat (4) @(posedge ref_clk);
      hw_sb_n <= 1'b1;
      sw_sb <= 1'b0;
      repeat (4) @(posedge ref_clk);
      see_run(16'h0000);
      rd(OFS_START, 32'h0);
      rd(OFS_MODE, 32'h0);
    end
    // reset in mid-run: flags drop at once and stay clear after release
    wr(OFS_CTR_BASE, 32'h100);
    wr(OFS_START, 32'h1);
    see_run(16'h0001);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    see_run(16'h0000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFS_START, 32'h0);
    rd(OFS_CTR_BASE, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
